//--- cvid_pkg.sv
// Constants and types for the core voltage identification controller.
// Assumes a single 250 MHz clock domain and a synchronous active-high reset.
package cvid_pkg;

    localparam int CVID_CODE_W = 6;
    localparam int CVID_TEMP_W = 8;
    localparam int CVID_FUSE_W = 12;

    // Code for the 0.9 V default level; lower codes mean lower voltage
    localparam logic [5:0] CVID_CODE_DEFAULT = 6'h0a;
    // Lowest code allowed, 0.85 V
    localparam logic [5:0] CVID_CODE_FLOOR = 6'h00;
    localparam logic [5:0] CVID_STEP = 6'h01;

    // Signed temperature in degrees Celsius; below zero forces default
    localparam logic signed [7:0] CVID_TEMP_COLD = 8'sh00;

    // Wait after any reset before the fuse register may be read
    localparam int CVID_QUIET_NS = 400;
    localparam int CVID_CLK_MHZ = 250;
    localparam int CVID_QUIET_CYC = (CVID_QUIET_NS * CVID_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] CVID_QUIET_CNT = 8'(CVID_QUIET_CYC);

    typedef enum logic [4:0] {
        CVID_ST_QUIET = 5'b00001,
        CVID_ST_FUSE = 5'b00010,
        CVID_ST_CALC = 5'b00100,
        CVID_ST_OFFER = 5'b01000,
        CVID_ST_WAIT = 5'b10000
    } cvid_state_t;

endpackage : cvid_pkg

//--- cvid_fuse_if.sv
// Fuse read handshake between the controller and its fuse reader.
// Assumes both ends run on the controller clock.
`timescale 1ns/1ps
interface cvid_fuse_if;
    logic req;
    logic done;
    logic [11:0] data;
    modport ctrl (output req, input done, input data);
    modport reader (input req, output done, output data);
endinterface : cvid_fuse_if

//--- cvid_fuse_reader.sv
// Fuse register reader: one registered read per request.
// Assumes the fuse array presents stable trim data on its input.
`timescale 1ns/1ps
module cvid_fuse_reader
    import cvid_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Fuse array side
    output logic fuse_rd,
    input wire logic [CVID_FUSE_W-1:0] fuse_data,
    // Controller side
    cvid_fuse_if.reader port
);
    logic pending;

    always_ff @(posedge clock) begin
        if (reset) begin
            pending <= 1'b0;
            fuse_rd <= 1'b0;
            port.done <= 1'b0;
            port.data <= '0;
        end else begin
            fuse_rd <= port.req & ~pending;
            pending <= port.req;
            port.done <= pending & port.req & ~port.done;
            if (pending) begin
                port.data <= fuse_data;
            end
        end
    end
endmodule : cvid_fuse_reader

//--- cvid_ctrl.sv
// Core voltage identification controller: trims plus temperature to a 6-bit code.
// Assumes the consumer acknowledges each offered code with a one-cycle or level ack.
`timescale 1ns/1ps
module cvid_ctrl
    import cvid_pkg::*;
#(
    parameter int CODE_W = CVID_CODE_W
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Device status
    input wire logic config_done,
    input wire logic signed [CVID_TEMP_W-1:0] temperature,
    // Fuse array
    output logic fuse_rd,
    input wire logic [CVID_FUSE_W-1:0] fuse_data,
    // Code handshake
    output logic [CODE_W-1:0] vid_code,
    output logic vid_code_avail,
    input wire logic vid_ack,
    // Status view of the held code
    output logic [CODE_W-1:0] control_status_register
);
    // The code path below is written for a 6-bit code only
    if (CODE_W != 6) begin : g_bad_width
        $error("cvid_ctrl supports a 6-bit code only");
    end

    cvid_fuse_if fuse_bus ();
    cvid_fuse_reader u_reader (
        .clock(clock),
        .reset(reset),
        .fuse_rd(fuse_rd),
        .fuse_data(fuse_data),
        .port(fuse_bus.reader)
    );

    cvid_state_t state;
    cvid_state_t next_state;
    logic [7:0] quiet;
    logic [11:0] trim;
    logic [5:0] code;
    logic [5:0] target;

    // Trim low six bits give the reduced code for 0 to 85 C (never used when cold); upper bits are a hot offset
    wire logic cold = temperature < CVID_TEMP_COLD;
    wire logic hot = temperature > 8'sh55;
    wire logic [5:0] trim_code = trim[5:0];
    wire logic [5:0] trim_hot = trim_code + trim[11:6];
    wire logic [5:0] trim_pick = hot ? trim_hot : trim_code;
    wire logic [5:0] trim_lim = (trim_pick > CVID_CODE_DEFAULT) ? CVID_CODE_DEFAULT : trim_pick;
    wire logic [5:0] reduced = (trim_lim < CVID_CODE_FLOOR) ? CVID_CODE_FLOOR : trim_lim;
    // Default before configuration and when cold
    wire logic [5:0] next_target = (!config_done || cold) ? CVID_CODE_DEFAULT : reduced;
    wire logic [5:0] code_up = code + CVID_STEP;
    wire logic [5:0] code_dn = code - CVID_STEP;
    // Single step keeps the regulator slew bounded
    wire logic [5:0] next_code = (target > code) ? code_up :
                                 (target < code) ? code_dn : code;
    wire logic quiet_done = quiet == 8'h00;
    wire logic acked = vid_code_avail & vid_ack;

    always_comb begin
        next_state = state;
        unique case (state)
            CVID_ST_QUIET: if (quiet_done) next_state = CVID_ST_FUSE;
            CVID_ST_FUSE: if (fuse_bus.done) next_state = CVID_ST_CALC;
            CVID_ST_CALC: next_state = CVID_ST_OFFER;
            CVID_ST_OFFER: next_state = CVID_ST_WAIT;
            CVID_ST_WAIT: if (acked) next_state = CVID_ST_CALC;
        endcase
    end

    // Fuse request held only outside reset and after the quiet time
    assign fuse_bus.req = (state == CVID_ST_FUSE);

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= CVID_ST_QUIET;
            quiet <= CVID_QUIET_CNT;
        end else begin
            state <= next_state;
            quiet <= quiet_done ? quiet : quiet - 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            trim <= '0;
            target <= CVID_CODE_DEFAULT;
        end else begin
            if (fuse_bus.done) begin
                trim <= fuse_bus.data;
            end
            if (state == CVID_ST_CALC) begin
                target <= next_target;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            code <= CVID_CODE_DEFAULT;
            vid_code <= CVID_CODE_DEFAULT;
            control_status_register <= CVID_CODE_DEFAULT;
            vid_code_avail <= 1'b0;
        end else begin
            // Every offer, the first included, steps code one toward target; the first is the default only while target is
            if (state == CVID_ST_OFFER) begin
                code <= next_code;
                vid_code <= next_code;
                control_status_register <= next_code;
                vid_code_avail <= 1'b1;
            end else if (acked) begin
                vid_code_avail <= 1'b0;
            end
        end
    end
endmodule : cvid_ctrl

//--- cvid_props.sv
// Port-level checks of the voltage id controller.
// Bound to cvid_ctrl; sees its ports only.
`timescale 1ns/1ps
module cvid_props
    import cvid_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic config_done,
    input wire logic signed [CVID_TEMP_W-1:0] temperature,
    input wire logic fuse_rd,
    input wire logic [CVID_CODE_W-1:0] vid_code,
    input wire logic vid_code_avail,
    input wire logic vid_ack,
    input wire logic [CVID_CODE_W-1:0] control_status_register
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [7:0] quiet;
    always_ff @(posedge clock) quiet <= reset ? 8'h00 : quiet + 8'(quiet != 8'hff);
    hold_offer_a: assert property (
        vid_code_avail && !vid_ack |=> vid_code_avail && $stable(vid_code)) else $error("offer");
    ack_next_a: assert property (
        vid_code_avail && vid_ack |=> !vid_code_avail ##1 !vid_code_avail ##1 vid_code_avail)
        else $error("ack");
    code_gated_a: assert property ($changed(vid_code) |-> $rose(vid_code_avail))
        else $error("code moved");
    one_step_a: assert property ($rose(vid_code_avail) |->
        6'(vid_code - $past(vid_code)) inside {6'h00, 6'h01, 6'h3f}) else $error("step");
    csr_copy_a: assert property (control_status_register == vid_code)
        else $error("status");
    cold_up_a: assert property ($rose(vid_code_avail) && temperature < 0
        && $past(temperature, 2) < 0 |-> vid_code == CVID_CODE_DEFAULT
        || vid_code == 6'($past(vid_code) + 1)) else $error("cold");
    boot_up_a: assert property ($rose(vid_code_avail) && !config_done
        && !$past(config_done, 2) |-> vid_code == CVID_CODE_DEFAULT
        || vid_code == 6'($past(vid_code) + 1)) else $error("boot");
    fuse_quiet_a: assert property (fuse_rd |-> quiet >= 8'(CVID_QUIET_CYC - 1))
        else $error("fuse early");
endmodule : cvid_props
bind cvid_ctrl cvid_props u_props (.clock, .reset, .config_done, .temperature, .fuse_rd,
    .vid_code, .vid_code_avail, .vid_ack, .control_status_register);

//--- cvid_consumer.sv
// Consumer model standing for the regulator interface logic.
// Acks each offered code one edge later unless told to stall.
`timescale 1ns/1ps
module cvid_consumer (
    input wire logic clock,
    input wire logic [5:0] vid_code,
    input wire logic vid_code_avail,
    input wire logic stall,
    output logic vid_ack,
    output logic [5:0] taken
);
    initial vid_ack = 1'b0;
    wire take = vid_code_avail && !stall && !vid_ack;
    always @(posedge clock) begin
        vid_ack <= take;
        if (take) taken <= vid_code;
    end
endmodule : cvid_consumer

//--- cvid_ctrl_bench.sv
// Self-checking bench: controller plus consumer model.
// Assumes trim 6'h04 in the fuse low field, no hot offset until the mid-run reset.
`timescale 1ns/1ps
module cvid_ctrl_bench import cvid_pkg::*;;
    logic clock = 1'b0, reset = 1'b1, config_done = 1'b0, stall = 1'b0;
    logic signed [7:0] temperature = 8'sh19;
    logic [11:0] fuse_data = 12'h004;
    logic [5:0] vid_code, control_status_register, taken;
    logic fuse_rd, vid_code_avail, vid_ack;
    int err_count = 0, tests_run = 0;
    initial forever #2 clock = ~clock;
    cvid_ctrl DUT (.clock, .reset, .config_done, .temperature, .fuse_rd, .fuse_data,
        .vid_code, .vid_code_avail, .vid_ack, .control_status_register);
    cvid_consumer user_side (.clock, .vid_code, .vid_code_avail, .stall, .vid_ack, .taken);
    task automatic chk(input string name, input logic [5:0] exp, input logic [5:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask : chk
    task automatic settle(input logic [5:0] exp);
        for (int i = 0; i < 200 && taken !== exp; i++) @(negedge clock);
    endtask : settle
    task automatic boot_default();
        settle(CVID_CODE_DEFAULT);
        chk("boot code", CVID_CODE_DEFAULT, taken);
    endtask : boot_default
    task automatic lower_trim();
        config_done = 1'b1;
        settle(6'h04);
        chk("trim code", 6'h04, taken);
        chk("status", 6'h04, control_status_register);
    endtask : lower_trim
    task automatic stall_cold();
        stall = 1'b1;
        repeat (20) @(negedge clock);
        temperature = 8'shfb;
        repeat (20) @(negedge clock);
        chk("held code", 6'h04, vid_code);
        chk("held avail", 6'h01, 6'(vid_code_avail));
        stall = 1'b0;
        settle(CVID_CODE_DEFAULT);
        chk("cold code", CVID_CODE_DEFAULT, taken);
    endtask : stall_cold
    // Mid-run reset re-reads fuses: hot offset of 2 on trim 4
    task automatic hot_reset();
        reset = 1'b1;
        stall = 1'b0;
        fuse_data = 12'h084;
        temperature = 8'sh64;
        repeat (16) @(negedge clock);
        reset = 1'b0;
        @(negedge clock);
        chk("reset code", CVID_CODE_DEFAULT, vid_code);
        chk("reset avail", 6'h00, 6'(vid_code_avail));
        settle(6'h06);
        chk("hot code", 6'h06, taken);
    endtask : hot_reset
    task automatic summarize();
        if (err_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (16) @(negedge clock);
        reset = 1'b0;
        boot_default();
        lower_trim();
        stall_cold();
        hot_reset();
        summarize();
    end
    initial begin
        #20000;
        err_count++;
        summarize();
    end
endmodule : cvid_ctrl_bench
